// ### tcc_consts.svh
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
// register byte addresses
`define TCC_ADDR_STD_CTRL 8'h00
`define TCC_ADDR_PAIR_CTRL 8'h04
`define TCC_ADDR_STD_COUNT 8'h08
`define TCC_ADDR_PRI_COUNT 8'h0c
`define TCC_ADDR_COMP_COUNT 8'h10
// control field positions
`define TCC_BIT_RUN 15
`define TCC_BIT_IDLE 13
`define TCC_BIT_GATE 6
`define TCC_BIT_PS_HI 5
`define TCC_BIT_PS_LO 4
`define TCC_BIT_PAIR32 3
`define TCC_BIT_SYNC 2
`define TCC_BIT_CSRC 1
// implemented bits of each control register
`define TCC_STD_CTRL_MASK 16'ha076
`define TCC_PAIR_CTRL_MASK 16'ha07a
// reset values
`define TCC_CTRL_RESET 16'h0000
`define TCC_COUNT_RESET 16'h0000
// prescaler terminal counts
`define TCC_PS_TC_1 8'h00
`define TCC_PS_TC_8 8'h07
`define TCC_PS_TC_64 8'h3f
`define TCC_PS_TC_256 8'hff
`endif

// ### tcc_ext_clock.sv
`timescale 1ns/1ps
module tcc_ext_clock #(
	parameter int HALF = 4
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic run_in,
	output logic pin_out
);
	int cnt;
	////////////////////////////////////////////////////////////////////////////////
	// pin stands low outside bursts; each phase lasts HALF cycles, well above two clocks
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in || !run_in) begin
			cnt <= 0;
			pin_out <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			pin_out <= ~pin_out;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : tcc_ext_clock

// ### tcc_pkg.sv
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_PS_1 = 2'b00,
		TCC_PS_8 = 2'b01,
		TCC_PS_64 = 2'b10,
		TCC_PS_256 = 2'b11
	} tcc_prescale_t;
	typedef enum logic {
		TCC_BUS_IDLE = 1'b0,
		TCC_BUS_ACK = 1'b1
	} tcc_bus_state_t;
endpackage : tcc_pkg

// ### tcc_prescaler.sv
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_prescaler
	import tcc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	tcc_tick_if.div tick
);
	logic [7:0] count;
	logic div_tick;
	logic [7:0] next_count;
	logic next_div_tick;
	logic [7:0] terminal;

	always_comb begin
		case (tick.prescale)
			TCC_PS_1: terminal = `TCC_PS_TC_1;
			TCC_PS_8: terminal = `TCC_PS_TC_8;
			TCC_PS_64: terminal = `TCC_PS_TC_64;
			TCC_PS_256: terminal = `TCC_PS_TC_256;
			default: terminal = `TCC_PS_TC_1;
		endcase
		next_count = count;
		next_div_tick = 1'b0;
		if (tick.clear) begin
			next_count = 8'h00;
		end else if (tick.raw_tick) begin
			if (count >= terminal) begin
				next_count = 8'h00;
				next_div_tick = 1'b1;
			end else begin
				next_count = count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			count <= 8'h00;
			div_tick <= 1'b0;
		end else begin
			count <= next_count;
			div_tick <= next_div_tick;
		end
	end

	assign tick.div_tick = div_tick;

	undivided_pass_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(tick.prescale == TCC_PS_1 && tick.raw_tick && !tick.clear) |=> div_tick)
		else $error("undivided tick lost");
	div_256_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(tick.prescale == TCC_PS_256 && $stable(tick.prescale) && div_tick) |-> $past(count) == 8'hff)
		else $error("1:256 output early");
	div_8_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(tick.prescale == TCC_PS_8 && $stable(tick.prescale) && div_tick) |-> $past(count) == 8'h07)
		else $error("1:8 output early");
endmodule : tcc_prescaler

// ### tcc_sync.sv
`timescale 1ns/1ps
module tcc_sync (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic pin_in,
	output logic level_out
);
	logic stage_a;
	logic stage_b;
	logic next_stage_a;
	logic next_stage_b;

	always_comb begin
		next_stage_a = pin_in;
		next_stage_b = stage_a;
	end

	// stage_a is read by stage_b only
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			stage_a <= 1'b0;
			stage_b <= 1'b0;
		end else begin
			stage_a <= next_stage_a;
			stage_b <= next_stage_b;
		end
	end

	assign level_out = stage_b;
endmodule : tcc_sync

// ### tcc_tick_if.sv
`timescale 1ns/1ps
interface tcc_tick_if;
	import tcc_pkg::*;
	logic raw_tick;
	logic clear;
	tcc_prescale_t prescale;
	logic div_tick;
	modport feed (output raw_tick, output clear, output prescale, input div_tick);
	modport div (input raw_tick, input clear, input prescale, output div_tick);
endinterface : tcc_tick_if

// ### tcc_top.sv
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_top
	import tcc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic ext_clock_input_pin_in,
	input wire logic pair_ext_clock_input_pin_in,
	input wire logic idle_mode_in,
	output logic [15:0] standalone_count_out,
	output logic [31:0] pair_count_out
);
	////////////////////////////////////////////////////////////////
	// register state
	logic [15:0] standalone_timer_control;
	logic [15:0] pairable_timer_control;
	logic [15:0] standalone_counter;
	logic [15:0] primary_counter;
	logic [15:0] companion_counter;
	tcc_bus_state_t bus_state;
	logic waitreq;
	logic [31:0] rdata;
	logic [15:0] next_standalone_timer_control;
	logic [15:0] next_pairable_timer_control;
	logic [15:0] next_standalone_counter;
	logic [15:0] next_primary_counter;
	logic [15:0] next_companion_counter;
	tcc_bus_state_t next_bus_state;
	logic next_waitreq;
	logic [31:0] next_rdata;

	// tick path state
	logic int_phase;
	logic std_pin_d;
	logic pair_pin_d;
	logic std_sync_tick;
	logic next_int_phase;
	logic next_std_pin_d;
	logic next_pair_pin_d;
	logic next_std_sync_tick;

	logic std_pin_s;
	logic pair_pin_s;
	logic bus_wr;
	logic [15:0] wr_lo;
	logic std_run;
	logic pair_run;
	logic std_src_tick;
	logic pair_src_tick;
	logic std_count_tick;
	logic [31:0] pair_sum;

	tcc_tick_if std_tick ();
	tcc_tick_if pair_tick ();

	////////////////////////////////////////////////////////////////
	// pin synchronisers and prescalers
	tcc_sync u_std_sync (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pin_in(ext_clock_input_pin_in),
		.level_out(std_pin_s)
	);

	tcc_sync u_pair_sync (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.pin_in(pair_ext_clock_input_pin_in),
		.level_out(pair_pin_s)
	);

	tcc_prescaler u_std_ps (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.tick(std_tick.div)
	);

	tcc_prescaler u_pair_ps (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.tick(pair_tick.div)
	);

	////////////////////////////////////////////////////////////////
	// clock source selection
	always_comb begin
		std_run = standalone_timer_control[`TCC_BIT_RUN]
			&& !(standalone_timer_control[`TCC_BIT_IDLE] && idle_mode_in);
		pair_run = pairable_timer_control[`TCC_BIT_RUN]
			&& !(pairable_timer_control[`TCC_BIT_IDLE] && idle_mode_in);
		if (standalone_timer_control[`TCC_BIT_CSRC]) begin
			std_src_tick = std_pin_s && !std_pin_d;
		end else if (standalone_timer_control[`TCC_BIT_GATE]) begin
			std_src_tick = int_phase && std_pin_s;
		end else begin
			std_src_tick = int_phase;
		end
		if (pairable_timer_control[`TCC_BIT_CSRC]) begin
			pair_src_tick = pair_pin_s && !pair_pin_d;
		end else if (pairable_timer_control[`TCC_BIT_GATE]) begin
			pair_src_tick = int_phase && pair_pin_s;
		end else begin
			pair_src_tick = int_phase;
		end
		// prescaler restarts whenever the timer is stopped
		std_tick.raw_tick = std_run && std_src_tick;
		std_tick.clear = !std_run;
		std_tick.prescale = tcc_prescale_t'(standalone_timer_control[`TCC_BIT_PS_HI:`TCC_BIT_PS_LO]);
		pair_tick.raw_tick = pair_run && pair_src_tick;
		pair_tick.clear = !pair_run;
		pair_tick.prescale = tcc_prescale_t'(pairable_timer_control[`TCC_BIT_PS_HI:`TCC_BIT_PS_LO]);
		next_std_sync_tick = std_tick.div_tick;
		if (standalone_timer_control[`TCC_BIT_CSRC] && standalone_timer_control[`TCC_BIT_SYNC]) begin
			std_count_tick = std_sync_tick;
		end else begin
			std_count_tick = std_tick.div_tick;
		end
		next_int_phase = !int_phase;
		next_std_pin_d = std_pin_s;
		next_pair_pin_d = pair_pin_s;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			int_phase <= 1'b0;
			std_pin_d <= 1'b0;
			pair_pin_d <= 1'b0;
			std_sync_tick <= 1'b0;
		end else begin
			int_phase <= next_int_phase;
			std_pin_d <= next_std_pin_d;
			pair_pin_d <= next_pair_pin_d;
			std_sync_tick <= next_std_sync_tick;
		end
	end

	////////////////////////////////////////////////////////////////
	// bus slave, control registers and counters
	always_comb begin
		bus_wr = (bus_state == TCC_BUS_ACK) && avs_write_in;
		wr_lo[7:0] = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;
		wr_lo[15:8] = avs_byteenable_in[1] ? avs_writedata_in[15:8] : 8'h00;
		pair_sum = {companion_counter, primary_counter} + 32'h0000_0001;
		next_standalone_timer_control = standalone_timer_control;
		next_pairable_timer_control = pairable_timer_control;
		next_standalone_counter = standalone_counter;
		next_primary_counter = primary_counter;
		next_companion_counter = companion_counter;
		next_rdata = rdata;
		if (std_count_tick && std_run) begin
			next_standalone_counter = standalone_counter + 16'h0001;
		end
		if (pair_tick.div_tick && pair_run) begin
			if (pairable_timer_control[`TCC_BIT_PAIR32]) begin
				next_primary_counter = pair_sum[15:0];
				next_companion_counter = pair_sum[31:16];
			end else begin
				next_primary_counter = primary_counter + 16'h0001;
			end
		end
		// software write wins over a count in the same cycle
		if (bus_wr) begin
			case (avs_address_in)
				`TCC_ADDR_STD_CTRL: next_standalone_timer_control = wr_lo & `TCC_STD_CTRL_MASK;
				`TCC_ADDR_PAIR_CTRL: next_pairable_timer_control = wr_lo & `TCC_PAIR_CTRL_MASK;
				`TCC_ADDR_STD_COUNT: next_standalone_counter = wr_lo;
				`TCC_ADDR_PRI_COUNT: next_primary_counter = wr_lo;
				`TCC_ADDR_COMP_COUNT: next_companion_counter = wr_lo;
				default: next_rdata = rdata;
			endcase
		end
		case (bus_state)
			TCC_BUS_IDLE: begin
				next_bus_state = (avs_read_in || avs_write_in) ? TCC_BUS_ACK : TCC_BUS_IDLE;
				next_rdata = 32'h0000_0000;
				case (avs_address_in)
					`TCC_ADDR_STD_CTRL: begin
						next_rdata[15:0] = standalone_timer_control;
						if (!standalone_timer_control[`TCC_BIT_CSRC]) begin
							next_rdata[`TCC_BIT_SYNC] = 1'b0;
						end
					end
					`TCC_ADDR_PAIR_CTRL: next_rdata[15:0] = pairable_timer_control;
					`TCC_ADDR_STD_COUNT: next_rdata[15:0] = standalone_counter;
					`TCC_ADDR_PRI_COUNT: next_rdata[15:0] = primary_counter;
					`TCC_ADDR_COMP_COUNT: next_rdata[15:0] = companion_counter;
					default: next_rdata = 32'h0000_0000;
				endcase
			end
			TCC_BUS_ACK: next_bus_state = TCC_BUS_IDLE;
			default: next_bus_state = TCC_BUS_IDLE;
		endcase
		next_waitreq = (next_bus_state != TCC_BUS_ACK);
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			standalone_timer_control <= `TCC_CTRL_RESET;
			pairable_timer_control <= `TCC_CTRL_RESET;
			standalone_counter <= `TCC_COUNT_RESET;
			primary_counter <= `TCC_COUNT_RESET;
			companion_counter <= `TCC_COUNT_RESET;
			bus_state <= TCC_BUS_IDLE;
			waitreq <= 1'b1;
			rdata <= 32'h0000_0000;
		end else begin
			standalone_timer_control <= next_standalone_timer_control;
			pairable_timer_control <= next_pairable_timer_control;
			standalone_counter <= next_standalone_counter;
			primary_counter <= next_primary_counter;
			companion_counter <= next_companion_counter;
			bus_state <= next_bus_state;
			waitreq <= next_waitreq;
			rdata <= next_rdata;
		end
	end

	assign avs_readdata_out = rdata;
	assign avs_waitrequest_out = waitreq;
	assign standalone_count_out = standalone_counter;
	assign pair_count_out = {companion_counter, primary_counter};

	////////////////////////////////////////////////////////////////
	// checks
	// gate ignored on pin
	gate_ignored_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(std_run && standalone_timer_control[`TCC_BIT_CSRC]) |-> std_tick.raw_tick == (std_pin_s && !std_pin_d))
		else $error("gate affected external count");
	gate_closed_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(!standalone_timer_control[`TCC_BIT_CSRC] && standalone_timer_control[`TCC_BIT_GATE] && !std_pin_s)
		|-> !std_tick.raw_tick)
		else $error("gated timer counted with gate low");
	gate_open_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(std_run && !standalone_timer_control[`TCC_BIT_CSRC] && standalone_timer_control[`TCC_BIT_GATE]
		&& std_pin_s && int_phase) |-> std_tick.raw_tick)
		else $error("gated timer missed tick with gate high");
	sync_delay_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(std_tick.div_tick && standalone_timer_control[`TCC_BIT_CSRC] && standalone_timer_control[`TCC_BIT_SYNC]
		&& $stable(standalone_timer_control)) |-> !std_count_tick ##1 std_count_tick)
		else $error("synchronized tick not delayed");
	sync_reads_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(bus_state == TCC_BUS_IDLE && avs_read_in && avs_address_in == `TCC_ADDR_STD_CTRL
		&& !standalone_timer_control[`TCC_BIT_CSRC]) |=> !avs_readdata_out[`TCC_BIT_SYNC])
		else $error("sync bit read as one");
	int_half_rate_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(std_tick.raw_tick && !standalone_timer_control[`TCC_BIT_CSRC]) |=> !std_tick.raw_tick)
		else $error("internal tick faster than half rate");
	int_source_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(std_run && !standalone_timer_control[`TCC_BIT_CSRC] && !standalone_timer_control[`TCC_BIT_GATE]
		&& int_phase) |-> std_tick.raw_tick)
		else $error("internal tick missing");
	pair_carry_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(pair_run && pair_tick.div_tick && pairable_timer_control[`TCC_BIT_PAIR32] && primary_counter == 16'hffff
		&& !bus_wr) |=> companion_counter == $past(companion_counter) + 16'h0001)
		else $error("32-bit pair lost carry");
	pair_stopped_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(!pairable_timer_control[`TCC_BIT_RUN] && !bus_wr) |=> $stable(pair_count_out))
		else $error("stopped pair counted");
	stopped_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(!standalone_timer_control[`TCC_BIT_RUN] && !std_sync_tick && !bus_wr) |=> $stable(standalone_counter))
		else $error("stopped timer counted");
	idle_halt_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(idle_mode_in && pairable_timer_control[`TCC_BIT_IDLE]) |-> !pair_tick.raw_tick)
		else $error("timer ran in idle");
	separate_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(!pairable_timer_control[`TCC_BIT_PAIR32] && !bus_wr) |=> $stable(companion_counter))
		else $error("companion moved in 16-bit mode");
	pair_joined_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(pair_run && pair_tick.div_tick && pairable_timer_control[`TCC_BIT_PAIR32] && !bus_wr)
		|=> pair_count_out == $past(pair_count_out) + 32'h0000_0001)
		else $error("joined pair did not step by one");
endmodule : tcc_top

// ### tcc_top_tb.sv
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_top_tb;
	typedef struct {logic pair; logic [15:0] ctrl; logic ext; logic idle; int win; int exp;} tcc_row_t;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] address = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'h3;
	logic [31:0] rdata;
	logic waitreq;
	logic ext_run = 1'b0;
	logic idle = 1'b0;
	logic pin_a;
	logic pin_b;
	logic [15:0] std_cnt;
	logic [31:0] pair_cnt;
	int errors = 0;
	int total_checks = 0;
	// external pin phases last 4 clocks, so one rising edge every 8 clocks
	tcc_row_t rows [16] = '{
		'{1'b0, 16'h8000, 1'b0, 1'b0, 64, 32},
		'{1'b0, 16'h8010, 1'b0, 1'b0, 256, 16},
		'{1'b0, 16'h8020, 1'b0, 1'b0, 2048, 16},
		'{1'b0, 16'h8030, 1'b0, 1'b0, 4096, 8},
		'{1'b0, 16'h0030, 1'b0, 1'b0, 256, 0},
		'{1'b0, 16'h8040, 1'b0, 1'b0, 256, 0},
		'{1'b0, 16'h8040, 1'b1, 1'b0, 256, 64},
		'{1'b0, 16'h8042, 1'b1, 1'b0, 256, 32},
		'{1'b0, 16'h8006, 1'b1, 1'b0, 256, 32},
		'{1'b0, 16'h8002, 1'b1, 1'b0, 256, 32},
		'{1'b0, 16'ha000, 1'b0, 1'b1, 256, 0},
		'{1'b0, 16'h8000, 1'b0, 1'b1, 256, 128},
		'{1'b1, 16'h8008, 1'b0, 1'b0, 64, 32},
		'{1'b1, 16'h0008, 1'b0, 1'b0, 256, 0},
		'{1'b1, 16'h8012, 1'b1, 1'b0, 512, 8},
		'{1'b1, 16'ha000, 1'b0, 1'b1, 256, 0}
	};
	logic [31:0] c0;
	logic [31:0] d;
	logic [31:0] v;
	tcc_top dut (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.avs_address_in(address),
		.avs_read_in(rd),
		.avs_write_in(wr),
		.avs_writedata_in(wdata),
		.avs_byteenable_in(be),
		.avs_readdata_out(rdata),
		.avs_waitrequest_out(waitreq),
		.ext_clock_input_pin_in(pin_a),
		.pair_ext_clock_input_pin_in(pin_b),
		.idle_mode_in(idle),
		.standalone_count_out(std_cnt),
		.pair_count_out(pair_cnt)
	);
	tcc_ext_clock src_a (.clk_in(clk_in), .reset_in(reset_in), .run_in(ext_run), .pin_out(pin_a));
	tcc_ext_clock src_b (.clk_in(clk_in), .reset_in(reset_in), .run_in(ext_run), .pin_out(pin_b));
	initial begin
		forever #2.5 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk
	// waitrequest and read data are taken at the rising edge itself, before the slave's flops move
	task automatic bus(input logic is_wr, input logic [7:0] a, input logic [15:0] dat, output logic [31:0] q);
		int i;
		q = 32'h0;
		@(posedge clk_in);
		address <= a;
		wdata <= {16'h0, dat};
		rd <= !is_wr;
		wr <= is_wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_in);
			if (waitreq === 1'b0) begin
				q = rdata;
				rd <= 1'b0;
				wr <= 1'b0;
				return;
			end
		end
		chk(1'b0, "bus timeout");
		stop_test();
	endtask : bus
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_in);
	endtask : wait_n
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		foreach (rows[i]) begin
			ext_run <= rows[i].ext;
			idle <= rows[i].idle;
			bus(1'b1, rows[i].pair ? `TCC_ADDR_PAIR_CTRL : `TCC_ADDR_STD_CTRL, 16'h0, v);
			bus(1'b1, rows[i].pair ? `TCC_ADDR_PRI_COUNT : `TCC_ADDR_STD_COUNT, 16'h0, v);
			bus(1'b1, rows[i].pair ? `TCC_ADDR_PAIR_CTRL : `TCC_ADDR_STD_CTRL, rows[i].ctrl, v);
			wait_n(16);
			c0 = rows[i].pair ? pair_cnt : {16'h0, std_cnt};
			wait_n(rows[i].win);
			d = (rows[i].pair ? pair_cnt : {16'h0, std_cnt}) - c0;
			// edge alignment of the window may shift a running count by one
			chk(d + 1 >= rows[i].exp && d <= rows[i].exp + (rows[i].exp > 0), "count rate");
		end
		ext_run <= 1'b0;
		idle <= 1'b0;
		// pair carry
		bus(1'b1, `TCC_ADDR_PAIR_CTRL, 16'h0, v);
		bus(1'b1, `TCC_ADDR_PRI_COUNT, 16'hfff0, v);
		bus(1'b1, `TCC_ADDR_COMP_COUNT, 16'h0, v);
		bus(1'b1, `TCC_ADDR_PAIR_CTRL, 16'h8008, v);
		wait_n(64);
		chk(pair_cnt[31:16] === 16'h0001, "no carry into companion");
		bus(1'b1, `TCC_ADDR_PAIR_CTRL, 16'h0, v);
		bus(1'b1, `TCC_ADDR_PRI_COUNT, 16'hfff0, v);
		bus(1'b1, `TCC_ADDR_COMP_COUNT, 16'h0, v);
		bus(1'b1, `TCC_ADDR_PAIR_CTRL, 16'h8000, v);
		wait_n(64);
		chk(pair_cnt[31:16] === 16'h0000, "companion moved in 16-bit mode");
		// readback of implemented bits
		bus(1'b1, `TCC_ADDR_STD_CTRL, 16'hffff, v);
		bus(1'b0, `TCC_ADDR_STD_CTRL, 16'h0, v);
		chk(v === {16'h0, `TCC_STD_CTRL_MASK}, "standalone control readback");
		bus(1'b1, `TCC_ADDR_PAIR_CTRL, 16'hffff, v);
		bus(1'b0, `TCC_ADDR_PAIR_CTRL, 16'h0, v);
		chk(v === {16'h0, `TCC_PAIR_CTRL_MASK}, "pair control readback");
		bus(1'b1, `TCC_ADDR_STD_CTRL, 16'h0004, v);
		bus(1'b0, `TCC_ADDR_STD_CTRL, 16'h0, v);
		chk(v === 32'h0, "sync bit visible on internal clock");
		// unmapped place
		bus(1'b1, 8'h20, 16'hffff, v);
		bus(1'b0, 8'h20, 16'h0, v);
		chk(v === 32'h0, "unmapped read not zero");
		bus(1'b0, `TCC_ADDR_STD_CTRL, 16'h0, v);
		chk(v === 32'h0, "unmapped write leaked");
		// second reset in mid-run
		bus(1'b1, `TCC_ADDR_STD_CTRL, 16'h8000, v);
		wait_n(20);
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		wait_n(2);
		chk(std_cnt === 16'h0 && pair_cnt === 32'h0, "counts after reset");
		bus(1'b0, `TCC_ADDR_STD_CTRL, 16'h0, v);
		chk(v === 32'h0, "standalone control reset value");
		bus(1'b0, `TCC_ADDR_PAIR_CTRL, 16'h0, v);
		chk(v === 32'h0, "pair control reset value");
		wait_n(32);
		chk(std_cnt === 16'h0, "timer runs after reset");
		stop_test();
	end
endmodule : tcc_top_tb
